// file: src/signal_modulator.sv
// Data signal modulator: mixes a selected modulator signal with a high or low carrier.
// Assumes an APB master on sys_clk and asynchronous source signals that are synchronised here.
`timescale 1ns/100ps
module signal_modulator
  import modulator_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous signal sources.
  input  wire logic [3:0]  pwm_unit_out,
  input  wire logic [1:0]  comparator_out,
  input  wire logic [1:0]  spi_data_out,
  input  wire logic        uart_tx_out,
  input  wire logic        reference_clock_signal,
  input  wire logic        carrier_input_pin_one,
  input  wire logic        carrier_input_pin_two,
  input  wire logic        modulator_input_pin,
  // Source pin drive disables, one bit per PWM, SPI, UART and reference clock source.
  output logic [3:0]       pwm_pin_disable,
  output logic [1:0]       spi_pin_disable,
  output logic             uart_pin_disable,
  output logic             refclk_pin_disable,
  // Output pin.
  output logic             modulated_output_pin,
  output logic             slew_limit_enable
);
  import modulator_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  localparam int NSRC = 13;
  logic [NSRC-1:0] raw_src;
  logic [NSRC-1:0] src_s;

  assign raw_src = {modulator_input_pin, carrier_input_pin_two, carrier_input_pin_one,
                    reference_clock_signal, uart_tx_out, spi_data_out, comparator_out, pwm_unit_out};

  input_sync #(
    .WIDTH (NSRC)
  ) u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in (raw_src),
    .sync_out (src_s)
  );

  logic [3:0] pwm_s;
  logic [1:0] cmp_s;
  logic [1:0] spi_s;
  logic       uart_s;
  logic       refclk_s;
  logic       cpin1_s;
  logic       cpin2_s;
  logic       mpin_s;

  assign pwm_s    = src_s[3:0];
  assign cmp_s    = src_s[5:4];
  assign spi_s    = src_s[7:6];
  assign uart_s   = src_s[8];
  assign refclk_s = src_s[9];
  assign cpin1_s  = src_s[10];
  assign cpin2_s  = src_s[11];
  assign mpin_s   = src_s[12];

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] control_q;
  logic [7:0] source_q;
  logic [7:0] high_carr_q;
  logic [7:0] low_carr_q;
  logic       mod_out_q;

  logic       wr_en;
  logic       rd_hit;
  logic       addr_ok;

  assign addr_ok = (paddr == OFF_CONTROL) || (paddr == OFF_SOURCE_SEL) ||
                   (paddr == OFF_HIGH_CARR) || (paddr == OFF_LOW_CARR);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_hit  = psel && penable && !pwrite && addr_ok;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] wd,
                                       input logic [7:0] wmask);
    merge = (old & ~wmask) | (wd[7:0] & wmask);
  endfunction : merge

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      control_q   <= CONTROL_RESET;
      source_q    <= SOURCE_RESET;
      high_carr_q <= CARRIER_RESET;
      low_carr_q  <= CARRIER_RESET;
    end else if (wr_en) begin
      if (paddr == OFF_CONTROL)    control_q   <= merge(control_q, pwdata, CONTROL_WMASK);
      if (paddr == OFF_SOURCE_SEL) source_q    <= merge(source_q, pwdata, SOURCE_WMASK);
      if (paddr == OFF_HIGH_CARR)  high_carr_q <= merge(high_carr_q, pwdata, CARRIER_WMASK);
      if (paddr == OFF_LOW_CARR)   low_carr_q  <= merge(low_carr_q, pwdata, CARRIER_WMASK);
    end
  end

  logic [7:0] rd_byte;

  assign rd_byte = (paddr == OFF_CONTROL)    ? {control_q[7:4], mod_out_q, 2'b00, control_q[0]} :
                   (paddr == OFF_SOURCE_SEL) ? {source_q[7], 3'b000, source_q[3:0]} :
                   (paddr == OFF_HIGH_CARR)  ? high_carr_q :
                   (paddr == OFF_LOW_CARR)   ? low_carr_q : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end else if (!rd_hit) begin
      prdata <= prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection.

  logic       enabled;
  logic       sw_bit;
  logic [3:0] mod_code;
  logic [3:0] high_code;
  logic [3:0] low_code;

  assign enabled   = control_q[CTL_MODULE_ENABLE];
  assign sw_bit    = control_q[CTL_SW_BIT];
  // Disabled module grounds both carriers and falls back to the software bit.
  assign mod_code  = enabled ? source_q[3:0] : MSRC_SW_BIT;
  assign high_code = enabled ? high_carr_q[3:0] : CSRC_GROUND;
  assign low_code  = enabled ? low_carr_q[3:0] : CSRC_GROUND;

  function automatic logic carrier_pick(input logic [3:0] code, input logic c1, input logic c2,
                                        input logic rc, input logic [3:0] pwm);
    logic [3:0] rel;
    rel = code - CSRC_PWM1;
    if (code == CSRC_PIN_ONE)      carrier_pick = c1;
    else if (code == CSRC_PIN_TWO) carrier_pick = c2;
    else if (code == CSRC_REFCLK)  carrier_pick = rc;
    else if (code[3:2] == 2'b01)   carrier_pick = pwm[rel[1:0]];
    else                           carrier_pick = 1'b0;
  endfunction : carrier_pick

  logic       mod_sig;
  logic [3:0] mrel;

  assign mrel    = mod_code - MSRC_PWM1;
  assign mod_sig = (mod_code == MSRC_SW_BIT)                    ? sw_bit :
                   (mod_code == MSRC_PIN)                       ? mpin_s :
                   (mod_code >= MSRC_PWM1 && mod_code < MSRC_CMP1) ? pwm_s[mrel[1:0]] :
                   (mod_code == MSRC_CMP1)                      ? cmp_s[0] :
                   (mod_code == MSRC_CMP1 + 4'h1)               ? cmp_s[1] :
                   (mod_code == MSRC_SPI1)                      ? spi_s[0] :
                   (mod_code == MSRC_SPI1 + 4'h1)               ? spi_s[1] :
                   (mod_code == MSRC_UART)                      ? uart_s : 1'b0;

  logic high_car;
  logic low_car;

  assign high_car = carrier_pick(high_code, cpin1_s, cpin2_s, refclk_s, pwm_s)
                    ^ (enabled & high_carr_q[CAR_INVERT]);
  assign low_car  = carrier_pick(low_code, cpin1_s, cpin2_s, refclk_s, pwm_s)
                    ^ (enabled & low_carr_q[CAR_INVERT]);

  ////////////////////////////////////////////////////////////////////////////
  // Carrier switching with optional synchronisation.

  carrier_sel_t cur_q;
  carrier_sel_t cur_d;
  logic         want_high;
  logic         cur_car;
  logic         cur_sync;

  assign want_high = mod_sig;
  assign cur_car   = (cur_q == CARRIER_HIGH) ? high_car : low_car;
  assign cur_sync  = enabled && ((cur_q == CARRIER_HIGH) ? high_carr_q[CAR_SYNC]
                                                         : low_carr_q[CAR_SYNC]);

  // A synchronised switch is held while the current carrier pulse is still high.
  always_comb begin
    cur_d = cur_q;
    unique case (cur_q)
      CARRIER_HIGH: begin
        if (!want_high && !(cur_sync && high_car)) cur_d = CARRIER_LOW;
      end
      CARRIER_LOW: begin
        if (want_high && !(cur_sync && low_car)) cur_d = CARRIER_HIGH;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cur_q <= CARRIER_LOW;
    end else begin
      cur_q <= cur_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mixing and output.

  logic mixed;
  logic next_car;

  assign next_car = (cur_d == CARRIER_HIGH) ? high_car : low_car;
  // The output is the carrier chosen by the switching logic, held over while a switch is pending.
  assign mixed    = enabled & next_car;

  logic out_val;
  logic pin_d;

  assign out_val = enabled & (mixed ^ control_q[CTL_OUT_INVERT]);
  assign pin_d   = control_q[CTL_PIN_OE] & out_val;

  logic pin_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mod_out_q <= 1'b0;
      pin_q     <= 1'b0;
    end else begin
      mod_out_q <= out_val;
      pin_q     <= pin_d;
    end
  end

  assign modulated_output_pin = pin_q;
  assign slew_limit_enable    = control_q[CTL_SLEW];

  ////////////////////////////////////////////////////////////////////////////
  // Default pin drive disables of the selected source peripherals.

  logic hdis;
  logic ldis;
  logic mdis;

  assign hdis = enabled & high_carr_q[CAR_PIN_DISABLE];
  assign ldis = enabled & low_carr_q[CAR_PIN_DISABLE];
  assign mdis = enabled & source_q[SRC_PIN_DISABLE];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pwm_dis
      assign pwm_pin_disable[gi] = (hdis && high_code == CSRC_PWM1 + 4'(gi)) ||
                                   (ldis && low_code == CSRC_PWM1 + 4'(gi))  ||
                                   (mdis && mod_code == MSRC_PWM1 + 4'(gi));
    end
    for (gi = 0; gi < 2; gi++) begin : g_spi_dis
      assign spi_pin_disable[gi] = mdis && (mod_code == MSRC_SPI1 + 4'(gi));
    end
  endgenerate

  assign uart_pin_disable   = mdis && (mod_code == MSRC_UART);
  assign refclk_pin_disable = (hdis && high_code == CSRC_REFCLK) ||
                              (ldis && low_code == CSRC_REFCLK);

endmodule : signal_modulator

// file: pkg/modulator_pkg.sv
// Package for the data signal modulator: register map, field positions, reset values, select codes.
// Assumes a 32-bit APB register bus with one aligned word per register.
package modulator_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFF_CONTROL     = 12'h000;
  localparam logic [11:0] OFF_SOURCE_SEL  = 12'h004;
  localparam logic [11:0] OFF_HIGH_CARR   = 12'h008;
  localparam logic [11:0] OFF_LOW_CARR    = 12'h00c;

  // Control register fields.
  localparam int CTL_MODULE_ENABLE = 7;
  localparam int CTL_PIN_OE        = 6;
  localparam int CTL_SLEW          = 5;
  localparam int CTL_OUT_INVERT    = 4;
  localparam int CTL_MOD_OUT       = 3;
  localparam int CTL_SW_BIT        = 0;

  // Source select and carrier control fields.
  localparam int SRC_PIN_DISABLE   = 7;
  localparam int CAR_PIN_DISABLE   = 7;
  localparam int CAR_INVERT        = 6;
  localparam int CAR_SYNC          = 5;

  // Writable masks and reset values.
  localparam logic [7:0] CONTROL_WMASK   = 8'hf1;
  localparam logic [7:0] SOURCE_WMASK    = 8'h8f;
  localparam logic [7:0] CARRIER_WMASK   = 8'hef;
  localparam logic [7:0] CONTROL_RESET   = 8'h20;
  localparam logic [7:0] SOURCE_RESET    = 8'h00;
  localparam logic [7:0] CARRIER_RESET   = 8'h00;

  // Modulator source codes.
  localparam logic [3:0] MSRC_SW_BIT   = 4'h0;
  localparam logic [3:0] MSRC_PIN      = 4'h1;
  localparam logic [3:0] MSRC_PWM1     = 4'h2;
  localparam logic [3:0] MSRC_CMP1     = 4'h6;
  localparam logic [3:0] MSRC_SPI1     = 4'h8;
  localparam logic [3:0] MSRC_UART     = 4'ha;

  // Carrier source codes.
  localparam logic [3:0] CSRC_GROUND   = 4'h0;
  localparam logic [3:0] CSRC_PIN_ONE  = 4'h1;
  localparam logic [3:0] CSRC_PIN_TWO  = 4'h2;
  localparam logic [3:0] CSRC_REFCLK   = 4'h3;
  localparam logic [3:0] CSRC_PWM1     = 4'h4;

  // Carrier currently being mixed.
  typedef enum logic [0:0] {
    CARRIER_LOW  = 1'b0,
    CARRIER_HIGH = 1'b1
  } carrier_sel_t;

endpackage : modulator_pkg

// file: src/input_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous inputs.
// Assumes the inputs are levels from pins or other clock domains.
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Signals.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : input_sync

// file: tb/signal_sources.sv
// Far-side model: peripheral outputs and pins feeding the modulator, as plain levels.
// Assumes the bench sets level_req by non-blocking assignment just after a clock edge.
`timescale 1ns/100ps
module signal_sources (
  // Requested levels: 3:0 pwm, 5:4 comparators, 7:6 spi, 8 uart, 9 refclk, 10-11 carrier pins, 12 modulator pin.
  input  wire logic [12:0] level_req,
  // Source outputs.
  output logic [3:0]       pwm_unit_out,
  output logic [1:0]       comparator_out,
  output logic [1:0]       spi_data_out,
  output logic             uart_tx_out,
  output logic             reference_clock_signal,
  output logic             carrier_input_pin_one,
  output logic             carrier_input_pin_two,
  output logic             modulator_input_pin
);
  // PWM units only ever present their PWM-mode output level.
  assign {modulator_input_pin, carrier_input_pin_two, carrier_input_pin_one, reference_clock_signal,
          uart_tx_out, spi_data_out, comparator_out, pwm_unit_out} = level_req;
endmodule : signal_sources

// file: tb/modulator_sva.sv
// Port checker for the modulator; enable bits are shadowed from APB writes.
// Assumes it is bound onto every signal_modulator instance.
`timescale 1ns/100ps
module modulator_sva
  import modulator_pkg::*;
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        nrst,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Outputs.
  input wire logic [3:0]  pwm_pin_disable,
  input wire logic        modulated_output_pin,
  input wire logic        slew_limit_enable
);
  logic en_q;
  logic oe_q;
  wire  acc = psel && penable;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      en_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (acc && pwrite && paddr == OFF_CONTROL) begin
      en_q <= pwdata[CTL_MODULE_ENABLE];
      oe_q <= pwdata[CTL_PIN_OE];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_ctl_write;
    acc && pwrite && paddr == OFF_CONTROL;
  endsequence
  sequence s_read(logic [11:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  ////////////////////////////////////////
  a_reset_defaults: assert property (disable iff (1'b0) !nrst |=> !modulated_output_pin && slew_limit_enable)
    else $error("outputs not at reset values");
  a_slew_follows: assert property (s_ctl_write |=> slew_limit_enable == $past(pwdata[CTL_SLEW]))
    else $error("slew enable did not follow write");
  a_slew_held: assert property (!(acc && pwrite && paddr == OFF_CONTROL) |=> $stable(slew_limit_enable))
    else $error("slew enable changed without write");
  a_pin_off_low: assert property (!$past(oe_q) |-> !modulated_output_pin)
    else $error("pin driven while output disabled");
  a_disabled_low: assert property (!$past(en_q) |-> !modulated_output_pin)
    else $error("pin driven while module disabled");
  a_disabled_no_drop: assert property (!en_q |-> pwm_pin_disable == 4'h0)
    else $error("pin drive removed while disabled");
  a_control_reserved: assert property (s_read(OFF_CONTROL) |-> prdata[2:1] == 2'b00)
    else $error("control reserved bits not zero");
  a_source_reserved: assert property (s_read(OFF_SOURCE_SEL) |-> prdata[6:4] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("source reserved bits not zero");
endmodule : modulator_sva

bind signal_modulator modulator_sva chk (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                                         .pslverr, .pwm_pin_disable, .modulated_output_pin, .slew_limit_enable);

// file: tb/signal_modulator_test.sv
// Self-checking bench for the modulator: APB register tasks and source levels.
// Assumes the checker is bound in and signal_sources stands for the peripherals.
`timescale 1ns/100ps
module signal_modulator_test;
  import modulator_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] level_req = 13'h0;
  logic [31:0] prdata;
  logic [3:0]  pwm_unit_out, pwm_pin_disable;
  logic [1:0]  comparator_out, spi_data_out, spi_pin_disable;
  logic        pready, pslverr, uart_tx_out, reference_clock_signal, uart_pin_disable, refclk_pin_disable;
  logic        carrier_input_pin_one, carrier_input_pin_two, modulator_input_pin;
  logic        modulated_output_pin, slew_limit_enable, err;
  logic [7:0]  rd;
  int          failures = 0;
  int          comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  signal_modulator dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pwm_unit_out, .comparator_out, .spi_data_out, .uart_tx_out, .reference_clock_signal, .carrier_input_pin_one,
    .carrier_input_pin_two, .modulator_input_pin, .pwm_pin_disable, .spi_pin_disable, .uart_pin_disable,
    .refclk_pin_disable, .modulated_output_pin, .slew_limit_enable);
  signal_sources src (.level_req, .pwm_unit_out, .comparator_out, .spi_data_out, .uart_tx_out,
    .reference_clock_signal, .carrier_input_pin_one, .carrier_input_pin_two, .modulator_input_pin);
  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'h0, data};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic rdc(input logic [11:0] addr, input logic [7:0] exp);
    apb(1'b0, addr, 8'h00);
    chk_reg(rd, exp);
  endtask : rdc
  // The pin settles three edges after a source change and one edge after a register write.
  task automatic pin_is(input logic exp);
    repeat (6) @(posedge sys_clk);
    chk_bit(modulated_output_pin, exp);
  endtask : pin_is
  task automatic wrap_up;
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  function automatic int msrc_bit(input int c);
    return (c == 1) ? 12 : c - 2;
  endfunction : msrc_bit
  function automatic int csrc_bit(input int c);
    return (c == 1) ? 10 : (c == 2) ? 11 : (c == 3) ? 9 : c - 4;
  endfunction : csrc_bit
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(OFF_CONTROL, 8'h20);
    rdc(OFF_SOURCE_SEL, 8'h00);
    apb(1'b1, OFF_SOURCE_SEL, 8'hff);
    rdc(OFF_SOURCE_SEL, 8'h8f);
    apb(1'b1, OFF_HIGH_CARR, 8'h83);
    apb(1'b1, OFF_LOW_CARR, 8'h87);
    apb(1'b1, 12'h010, 8'hff);
    chk_bit(err, 1'b1);
    rdc(12'h010, 8'h00);
    apb(1'b1, OFF_SOURCE_SEL, 8'h82);
    apb(1'b1, OFF_CONTROL, 8'h80);
    @(posedge sys_clk);
    chk_reg({4'h0, pwm_pin_disable}, 8'h09);
    chk_bit(refclk_pin_disable, 1'b1);
    apb(1'b1, OFF_SOURCE_SEL, 8'h8a);
    @(posedge sys_clk);
    chk_bit(uart_pin_disable, 1'b1);
    apb(1'b1, OFF_SOURCE_SEL, 8'h89);
    @(posedge sys_clk);
    chk_reg({6'h00, spi_pin_disable}, 8'h02);
    apb(1'b1, OFF_SOURCE_SEL, 8'h00);
    apb(1'b1, OFF_HIGH_CARR, 8'h00);
    apb(1'b1, OFF_LOW_CARR, 8'h00);
    apb(1'b1, OFF_CONTROL, 8'h11);
    pin_is(1'b0);
    rdc(OFF_CONTROL, 8'h11);
    chk_bit(slew_limit_enable, 1'b0);
    apb(1'b1, OFF_CONTROL, 8'hff);
    pin_is(1'b1);
    rdc(OFF_CONTROL, 8'hf9);
    apb(1'b1, OFF_HIGH_CARR, 8'h40);
    apb(1'b1, OFF_CONTROL, 8'hc1);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFF_SOURCE_SEL, 8'(c));
      level_req <= (c == 0) ? 13'h0 : (c > 10) ? 13'h1fff : 13'h1 << msrc_bit(c);
      pin_is(c <= 10);
      level_req <= (c >= 1 && c <= 10) ? ~(13'h1 << msrc_bit(c)) : 13'h0;
      pin_is(c == 0);
    end
    apb(1'b1, OFF_SOURCE_SEL, 8'h00);
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, OFF_HIGH_CARR, 8'h00);
      apb(1'b1, OFF_LOW_CARR, 8'h00);
      apb(1'b1, OFF_CONTROL, 8'hc0 | 8'(h));
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, h ? OFF_HIGH_CARR : OFF_LOW_CARR, 8'(c));
        level_req <= (c >= 1 && c <= 7) ? 13'h1 << csrc_bit(c) : 13'h1fff;
        pin_is(c >= 1 && c <= 7);
      end
    end
    apb(1'b1, OFF_SOURCE_SEL, 8'h01);
    apb(1'b1, OFF_HIGH_CARR, 8'h21);
    apb(1'b1, OFF_LOW_CARR, 8'h02);
    level_req <= 13'h1400;
    pin_is(1'b1);
    level_req <= 13'h0400;
    pin_is(1'b1);
    level_req <= 13'h0800;
    pin_is(1'b1);
    level_req <= 13'h1800;
    pin_is(1'b0);
    level_req <= 13'h1000;
    apb(1'b1, OFF_HIGH_CARR, 8'h41);
    pin_is(1'b1);
    apb(1'b1, OFF_CONTROL, 8'hd0);
    pin_is(1'b0);
    apb(1'b1, OFF_CONTROL, 8'h80);
    pin_is(1'b0);
    rdc(OFF_CONTROL, 8'h88);
    apb(1'b1, OFF_CONTROL, 8'hc0);
    pin_is(1'b1);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(OFF_CONTROL, 8'h20);
    rdc(OFF_HIGH_CARR, 8'h00);
    rdc(OFF_SOURCE_SEL, 8'h00);
    chk_bit(modulated_output_pin, 1'b0);
    wrap_up();
  end
  initial begin
    repeat (8000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
endmodule : signal_modulator_test
